// ==== rtcs_pkg.sv ====
// Purpose: Shared constants for the RTC power-up and soft-reset pair.
// Assumes: clk_sys at 100 MHz on both ends.
// Notes:   Long waits are derived here and become module parameters.
package rtcs_pkg;
	localparam int CLK_NS       = 10;
	localparam int SCLK_HALF    = 30;
	localparam int ACC_WAIT_MS  = 41;
	localparam int ACC_WAIT_CYC = ACC_WAIT_MS * 1000000 / CLK_NS;
	localparam int FLAG_TMO_MS  = 40;
	localparam int FLAG_TMO_CYC = FLAG_TMO_MS * 1000000 / CLK_NS;
	localparam int RST_WAIT_US  = 2100;
	localparam int RST_WAIT_CYC = RST_WAIT_US * 1000 / CLK_NS;
	localparam int POLL_NS      = 31250000;
	localparam int POLL_CYC_DEF = POLL_NS / CLK_NS;
	localparam int PROC_US      = 1000;
	localparam int PROC_CYC_DEF = PROC_US * 1000 / CLK_NS;
	localparam int CNT_W        = 24;
	////////////////////////////////////////////////////////////////////////
	localparam logic [3:0] HDR_BITS  = 4'h8;
	localparam logic [4:0] RISE_RD   = 5'h10;
	localparam logic [4:0] RISE_WR   = 5'h11;
	localparam int         MODE_RD   = 3;
	localparam logic [3:0] MODE_RD_B1 = 4'h9;
	localparam logic [3:0] MODE_WR_B1 = 4'h1;
	localparam logic [3:0] MODE_WR_B3 = 4'h3;
	localparam logic [3:0] MODE_WR_B5 = 4'h5;
	localparam int         MEM_N     = 112;
	localparam logic [6:0] MEM_BASE  = 7'h10;
	localparam logic [2:0] FLAG_BANK = 3'h1;
	localparam logic [3:0] FLAG_ADDR = 4'hE;
	localparam int         FLAG_BIT  = 1;
	localparam logic [2:0] TEST_BANK = 3'h3;
	localparam logic [3:0] TEST_ADDR = 4'hF;
	localparam int         TEST_BIT  = 7;
	localparam logic [3:0] IEN_ADDR  = 4'h2;
	localparam logic [2:0] SRST_BANK = 3'h5;
	localparam logic [3:0] SRST_LAST = 4'h3;
	localparam logic [7:0] IEN_CLR   = 8'h00;
	localparam logic [7:0] TEST_SET  = 8'h80;
	localparam logic [7:0] SRST_DATA [4] = '{8'h6C, 8'h03, 8'h10, 8'h20};
	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_CMD   = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_ISTAT = 8'h0C;
	localparam logic [7:0] OFS_IMASK = 8'h10;
	localparam int         CTRL_RST  = 0;
	localparam int         CTRL_FAST = 1;
	localparam int         CTRL_GO   = 2;
	localparam int         INT_W     = 3;
	localparam logic [2:0] IMASK_RST = 3'h0;
endpackage : rtcs_pkg

// ==== rtcs_if.sv ====
// Purpose: Four-wire serial link between host and RTC.
// Assumes: Separate data in and data out wires, so nothing is shared.
// Notes:   Host makes ce and sclk; the device only samples them.
`timescale 1ns/1ps
interface rtcs_if;
	logic ce;
	logic sclk;
	logic sdi;
	logic sdo;
	modport dev (input ce, input sclk, input sdi, output sdo);
	modport host (output ce, output sclk, output sdi, input sdo);
endinterface : rtcs_if

// ==== rtcs_dev.sv ====
// Purpose: RTC end: serial slave, supply tracking, power-on and soft reset.
// Assumes: All link and supply inputs are asynchronous to clk_sys.
// Notes:   Register banks 1 to 7, sixteen bytes each, in one array.
// Behaviour
// (R1) Device commits byte on rise after 8 bits.
// (R2) Aborted transfer leaves target register unchanged.
// (R3) Either supply rising triggers internal power-on reset.
// (R4) Backup mode polls main supply every 31.25 ms.
// (R5) No access within 30 ms of power-up.
// (R6) Wait 40 ms after return from backup.
// (R7) Keep chip-select low 40 ms at power-up.
// (R8) Initialise only after power-loss flag reads one.
// (R9) Wait, dummy read, then check power-loss flag.
// (R10) Clear interrupt enable, then set test bit.
// (R11) Write four fixed bytes to bank five.
// (R12) Wait over 2 ms; device clears test.
// (R13) Optionally clear flag repeatedly, give up after 40 ms.
// (R14) Set test bit even if flag reads zero.
// (R15) Never set test bit outside the sequence.
// (R16) Device sets power-loss flag on low supply; here it is set on each supply-rise power-on reset and on soft reset.
// (R17) Four-bit mode code selects bank and direction.
// (R18) Block other accesses during the reset sequence.
`timescale 1ns/1ps
module rtcs_dev
	import rtcs_pkg::*;
#(
	parameter int POLL_CYC = POLL_CYC_DEF,
	parameter int PROC_CYC = PROC_CYC_DEF
)(
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic main_ok,
	input  wire logic bat_ok,
	output logic      on_main,
	output logic      power_loss,
	output logic      test_on,
	rtcs_if.dev       bus
);
	logic [4:0]       s1, s2, s3, flt, prv;
	logic [CNT_W-1:0] poll_cnt, proc_cnt;
	logic             proc_on, sw_por, por_ev, poll_tick, main_up;
	logic [7:0]       mem [MEM_N];
	logic [7:0]       hdr, dsh, rsh, rd_byte;
	logic [3:0]       hc, addr;
	logic [2:0]       dc, rb, bank;
	logic             pend, rd, valid, hdr_done, bus_en, rise_ev, fall_ev;
	logic             wr_go, clr_all;
	logic [6:0]       idx;

	////////////////////////////////////////////////////////////////////////
	// A change is taken only once the second and third stages agree.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			s1  <= 5'h00;
			s2  <= 5'h00;
			s3  <= 5'h00;
			flt <= 5'h00;
			prv <= 5'h00;
		end
		else
		begin
			s1  <= {bat_ok, main_ok, bus.ce, bus.sclk, bus.sdi};
			s2  <= s1;
			s3  <= s2;
			flt <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & flt);
			prv <= flt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// On backup the main supply is only looked at on the poll tick.
	assign poll_tick = (poll_cnt == '0);
	assign main_up   = flt[3] && !on_main && (!flt[4] || poll_tick); // R4
	assign por_ev    = main_up || (flt[4] && !prv[4]); // R3
	assign clr_all   = por_ev || sw_por;

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			poll_cnt <= '0;
		else if (on_main || poll_tick)
			poll_cnt <= CNT_W'(POLL_CYC - 1); // R4
		else
			poll_cnt <= poll_cnt - 1'b1;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			on_main <= 1'b0;
		else if (!flt[3])
			on_main <= 1'b0;
		else if (main_up)
			on_main <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	assign bus_en   = on_main && flt[2];
	assign rise_ev  = bus_en && flt[1] && !prv[1];
	assign fall_ev  = bus_en && !flt[1] && prv[1];
	assign hdr_done = (hc == HDR_BITS);
	assign rd       = hdr[4 + MODE_RD]; // R17
	assign bank     = hdr[6:4];
	assign valid    = hdr_done && (bank != 3'h0);
	assign idx      = 7'({bank, addr}) - MEM_BASE;
	assign wr_go    = rise_ev && pend && !rd && valid; // R1

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			hdr  <= 8'h00;
			dsh  <= 8'h00;
			hc   <= 4'h0;
			dc   <= 3'h0;
			rb   <= 3'h0;
			pend <= 1'b0;
			addr <= 4'h0;
		end
		else if (!bus_en)
		begin
			hc   <= 4'h0;
			dc   <= 3'h0;
			rb   <= 3'h0;
			pend <= 1'b0; // R2
		end
		else if (rise_ev)
		begin
			if (!hdr_done)
			begin
				hdr <= {hdr[6:0], flt[0]};
				hc  <= hc + 1'b1;
				if (hc == HDR_BITS - 1'b1)
					addr <= {hdr[2:0], flt[0]};
			end
			else if (!rd)
			begin
				dsh  <= {dsh[6:0], flt[0]};
				dc   <= dc + 1'b1;
				pend <= (dc == 3'h7); // R1
				if (pend)
					addr <= addr + 1'b1;
			end
		end
		else if (fall_ev && hdr_done && rd)
		begin
			rb <= rb + 1'b1;
			if (rb == 3'h7)
				addr <= addr + 1'b1;
		end
	end

	always_comb
	begin
		rd_byte = valid ? mem[idx] : 8'h00;
		if (bank == FLAG_BANK && addr == FLAG_ADDR)
			rd_byte[FLAG_BIT] = power_loss;
		if (bank == TEST_BANK && addr == TEST_ADDR)
			rd_byte[TEST_BIT] = test_on;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			bus.sdo <= 1'b0;
			rsh     <= 8'h00;
		end
		else if (!bus_en)
			bus.sdo <= 1'b0;
		else if (fall_ev && hdr_done && rd)
		begin
			bus.sdo <= (rb == 3'h0) ? rd_byte[7] : rsh[7];
			rsh     <= (rb == 3'h0) ? {rd_byte[6:0], 1'b0} : {rsh[6:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < MEM_N; i++)
				mem[i] <= 8'h00;
		end
		else if (clr_all)
		begin
			for (int i = 0; i < MEM_N; i++)
				mem[i] <= 8'h00; // R3
		end
		else if (wr_go)
			mem[idx] <= dsh; // R1
	end

	// A supply event wins over a software clear in the same cycle.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			power_loss <= 1'b1;
		else if (clr_all)
			power_loss <= 1'b1; // R16
		else if (wr_go && bank == FLAG_BANK && addr == FLAG_ADDR)
			power_loss <= dsh[FLAG_BIT];
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			test_on <= 1'b0;
		else if (clr_all)
			test_on <= 1'b0; // R12
		else if (wr_go && bank == TEST_BANK && addr == TEST_ADDR)
			test_on <= dsh[TEST_BIT];
	end

	// The last soft-reset write arms a timer that ends in a full reset.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			proc_on  <= 1'b0;
			proc_cnt <= '0;
			sw_por   <= 1'b0;
		end
		else
		begin
			sw_por <= 1'b0;
			if (por_ev)
				proc_on <= 1'b0;
			else if (proc_on)
			begin
				proc_cnt <= proc_cnt - 1'b1;
				if (proc_cnt == '0)
				begin
					proc_on <= 1'b0;
					sw_por  <= 1'b1; // R12
				end
			end
			else if (wr_go && test_on && bank == SRST_BANK && addr == SRST_LAST)
			begin
				proc_on  <= 1'b1;
				proc_cnt <= CNT_W'(PROC_CYC - 1);
			end
		end
	end
endmodule : rtcs_dev

// ==== rtcs_host.sv ====
// Purpose: Host end: APB-controlled serial master and soft-reset sequencer.
// Assumes: APB3 without pslverr; main_ok is asynchronous to clk_sys.
// Notes:   Reset of this block is taken as the start of power-up.
`timescale 1ns/1ps
module rtcs_host
	import rtcs_pkg::*;
#(
	parameter int ACC_CYC = ACC_WAIT_CYC,
	parameter int TMO_CYC = FLAG_TMO_CYC,
	parameter int RST_CYC = RST_WAIT_CYC
)(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             irq,
	input  wire logic        main_ok,
	rtcs_if.host             bus
);
	typedef enum logic [4:0] {
		SQ_IDLE = 5'b00001,
		SQ_OP   = 5'b00010,
		SQ_CLR  = 5'b00100,
		SQ_POST = 5'b01000,
		SQ_USER = 5'b10000
	} rtcs_sq_e;
	typedef enum logic [4:0] {
		E_IDLE = 5'b00001,
		E_LO   = 5'b00010,
		E_HI   = 5'b00100,
		E_END  = 5'b01000,
		E_REC  = 5'b10000
	} rtcs_eng_e;

	localparam logic [2:0]  STEP_FLAG = 3'h1;
	localparam logic [2:0]  STEP_LAST = 3'h7;
	localparam logic [5:0]  HALF_M1   = 6'(SCLK_HALF - 1);
	localparam logic [15:0] FLAG_CLR  = {MODE_WR_B1, FLAG_ADDR, 8'h00};

	rtcs_sq_e         sq;
	rtcs_eng_e        es;
	logic [2:0]       sy_main, sy_sdo;
	logic             main_f, main_q, sdo_f;
	logic [CNT_W-1:0] acc_cnt, tmo_cnt, wait_cnt;
	logic             acc_rdy, fast_mode, flag_one;
	logic [15:0]      cmd, e_op, sh;
	logic [7:0]       rx, rdata;
	logic [4:0]       rc;
	logic [5:0]       tk;
	logic [2:0]       step;
	logic             e_go, e_done, e_rdq, fin_rst, fin_acc, fin_tmo;
	logic [INT_W-1:0] istat, imask, next_istat, w1c;
	logic             acc, wr, go_rst, go_usr;
	logic [31:0]      rd_mux;

	function automatic logic [15:0] seq_op(input logic [2:0] s);
		logic [15:0] op;
		op = {MODE_RD_B1, 4'h0, 8'h00}; // R9
		case (s)
			3'h1:    op = {MODE_RD_B1, FLAG_ADDR, 8'h00}; // R9
			3'h2:    op = {MODE_WR_B3, IEN_ADDR, IEN_CLR}; // R10
			3'h3:    op = {MODE_WR_B3, TEST_ADDR, TEST_SET}; // R10
			3'h4,
			3'h5,
			3'h6,
			3'h7:    op = {MODE_WR_B5, 2'b00, s[1:0], SRST_DATA[s[1:0]]}; // R11
			default: op = {MODE_RD_B1, 4'h0, 8'h00};
		endcase
		return op;
	endfunction : seq_op

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			sy_main <= 3'h0;
			sy_sdo  <= 3'h0;
			main_f  <= 1'b0;
			main_q  <= 1'b0;
			sdo_f   <= 1'b0;
		end
		else
		begin
			sy_main <= {sy_main[1:0], main_ok};
			sy_sdo  <= {sy_sdo[1:0], bus.sdo};
			if (sy_main[1] == sy_main[2])
				main_f <= sy_main[2];
			if (sy_sdo[1] == sy_sdo[2])
				sdo_f <= sy_sdo[2];
			main_q <= main_f;
		end
	end

	// Power-up and backup-return both restart the access wait.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			acc_cnt <= CNT_W'(ACC_CYC); // R5 R7
		else if (main_f && !main_q)
			acc_cnt <= CNT_W'(ACC_CYC); // R6
		else if (acc_cnt != '0)
			acc_cnt <= acc_cnt - 1'b1;
	end
	assign acc_rdy = (acc_cnt == '0) && main_f; // R5 R6 R7

	////////////////////////////////////////////////////////////////////////
	assign acc    = psel && penable && pready;
	assign wr     = acc && pwrite;
	assign go_rst = wr && paddr == OFS_CTRL && pwdata[CTRL_RST];
	assign go_usr = wr && paddr == OFS_CTRL && pwdata[CTRL_GO];
	assign w1c    = (wr && paddr == OFS_ISTAT) ? pwdata[INT_W-1:0] : '0;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			OFS_CTRL:  rd_mux[CTRL_FAST] = fast_mode;
			OFS_CMD:   rd_mux[15:0] = cmd;
			OFS_STAT:  rd_mux = {16'h0000, rdata, 5'h00, flag_one, acc_rdy, sq != SQ_IDLE};
			OFS_ISTAT: rd_mux[INT_W-1:0] = istat;
			OFS_IMASK: rd_mux[INT_W-1:0] = imask;
			default:   rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel && !penable;
			if (psel && !penable)
				prdata <= rd_mux;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			fast_mode <= 1'b0;
			cmd       <= 16'h0000;
			imask     <= IMASK_RST;
		end
		else if (wr)
		begin
			if (paddr == OFS_CTRL)
				fast_mode <= pwdata[CTRL_FAST];
			if (paddr == OFS_CMD)
				cmd <= pwdata[15:0];
			if (paddr == OFS_IMASK)
				imask <= pwdata[INT_W-1:0];
		end
	end

	// A completion in the same cycle as its clear stays set.
	assign next_istat = (istat & ~w1c) | {fin_tmo, fin_acc, fin_rst};
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			istat <= '0;
			irq   <= 1'b0;
		end
		else
		begin
			istat <= next_istat;
			irq   <= |(next_istat & imask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			tmo_cnt <= '0;
		else if (sq == SQ_IDLE && go_rst && acc_rdy)
			tmo_cnt <= CNT_W'(TMO_CYC); // R13
		else if (tmo_cnt != '0)
			tmo_cnt <= tmo_cnt - 1'b1;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			wait_cnt <= '0;
		else if (sq == SQ_OP && e_done && step == STEP_LAST)
			wait_cnt <= CNT_W'(RST_CYC); // R12
		else if (wait_cnt != '0)
			wait_cnt <= wait_cnt - 1'b1;
	end

	// User commands are only taken in idle, so the sequence runs alone.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			sq       <= SQ_IDLE;
			step     <= 3'h0;
			e_go     <= 1'b0;
			e_op     <= 16'h0000;
			flag_one <= 1'b0;
			rdata    <= 8'h00;
			fin_rst  <= 1'b0;
			fin_acc  <= 1'b0;
			fin_tmo  <= 1'b0;
		end
		else
		begin
			e_go    <= 1'b0;
			fin_rst <= 1'b0;
			fin_acc <= 1'b0;
			fin_tmo <= 1'b0;
			unique case (sq)
				SQ_IDLE:
				begin
					if (go_rst && acc_rdy)
					begin
						step <= 3'h0;
						e_op <= seq_op(3'h0); // R9
						e_go <= 1'b1;
						sq   <= SQ_OP;
					end
					else if (go_usr && acc_rdy) // R18
					begin
						e_op <= cmd;
						if (cmd[15:8] == {MODE_WR_B3, TEST_ADDR})
							e_op[TEST_BIT] <= 1'b0; // R15
						e_go <= 1'b1;
						sq   <= SQ_USER;
					end
				end
				SQ_USER:
					if (e_done)
					begin
						rdata   <= rx;
						fin_acc <= 1'b1;
						sq      <= SQ_IDLE;
					end
				SQ_OP:
					if (e_done)
					begin
						if (step == STEP_FLAG)
							flag_one <= rx[FLAG_BIT]; // R8
						if (step == STEP_FLAG && fast_mode && rx[FLAG_BIT] && tmo_cnt != '0)
						begin
							e_op <= FLAG_CLR; // R13
							e_go <= 1'b1;
							sq   <= SQ_CLR;
						end
						else if (step == STEP_LAST)
							sq <= SQ_POST;
						else
						begin
							if (step == STEP_FLAG && fast_mode && rx[FLAG_BIT])
								fin_tmo <= 1'b1; // R13
							step <= step + 1'b1;
							e_op <= seq_op(step + 1'b1); // R14
							e_go <= 1'b1;
						end
					end
				SQ_CLR:
					if (e_done)
					begin
						e_op <= seq_op(STEP_FLAG); // R13
						e_go <= 1'b1;
						sq   <= SQ_OP;
					end
				SQ_POST:
					if (wait_cnt == '0)
					begin
						fin_rst <= 1'b1; // R12 R18
						sq      <= SQ_IDLE;
					end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data changes on the falling edge; sdo is sampled at each rise.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			es       <= E_IDLE;
			tk       <= 6'h00;
			sh       <= 16'h0000;
			rx       <= 8'h00;
			rc       <= 5'h00;
			e_rdq    <= 1'b0;
			e_done   <= 1'b0;
			bus.ce   <= 1'b0;
			bus.sclk <= 1'b0;
			bus.sdi  <= 1'b0;
		end
		else
		begin
			e_done <= 1'b0;
			if (tk != 6'h00)
				tk <= tk - 1'b1;
			unique case (es)
				E_IDLE:
					if (e_go)
					begin
						sh      <= e_op;
						e_rdq   <= e_op[12 + MODE_RD]; // R17
						rc      <= 5'h00;
						bus.ce  <= 1'b1;
						bus.sdi <= e_op[15];
						tk      <= HALF_M1;
						es      <= E_LO;
					end
				E_LO:
					if (tk == 6'h00)
					begin
						bus.sclk <= 1'b1;
						rx       <= {rx[6:0], sdo_f};
						rc       <= rc + 1'b1;
						tk       <= HALF_M1;
						es       <= E_HI;
					end
				E_HI:
					if (tk == 6'h00)
					begin
						bus.sclk <= 1'b0;
						sh       <= {sh[14:0], 1'b0};
						bus.sdi  <= sh[14];
						tk       <= HALF_M1;
						es       <= (rc == (e_rdq ? RISE_RD : RISE_WR)) ? E_END : E_LO; // R1
					end
				E_END:
					if (tk == 6'h00)
					begin
						bus.ce <= 1'b0;
						tk     <= HALF_M1;
						es     <= E_REC;
					end
				E_REC:
					if (tk == 6'h00)
					begin
						e_done <= 1'b1;
						es     <= E_IDLE;
					end
			endcase
		end
	end
endmodule : rtcs_host

// ==== rtcs_assertions.sv ====
// Purpose: Wire-level checks on the serial link between host and RTC.
// Assumes: Host made with ACC_CYC as its access wait; sclk half period SCLK_HALF.
// Notes:   Sees the link signals only; device register effects are judged by the bench.
`timescale 1ns/1ps
module rtcs_assertions #(
	parameter int ACC_CYC = 2000
)(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic sclk_q;
	int   run;
	int   low;
	int   rises;
	int   since;
	////////////////////////////////////////
	// Counters restart with the host, so a mid-run reset reopens the power-up window.
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn) sclk_q <= 1'b0;
		else sclk_q <= sclk;
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn) run <= 0;
		else run <= (sclk != sclk_q) ? 0 : run + 1;
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn) low <= 0;
		else low <= ce ? 0 : low + 1;
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn) rises <= 0;
		else if (!ce) rises <= 0;
		else if (sclk && !sclk_q) rises <= rises + 1;
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn) since <= 0;
		else if (since < ACC_CYC) since <= since + 1;
	////////////////////////////////////////
	sequence s_clk_idle;
		!sclk [*8];
	endsequence
	sequence s_bit_held;
		sclk && $stable(sdi);
	endsequence
	a_ce_power_low: assert property (since < ACC_CYC |-> !ce)
		else $error("ce raised inside the power-up window");
	a_first_access: assert property ($rose(ce) |-> since == ACC_CYC)
		else $error("transfer started before the access wait ended");
	a_sclk_idle: assert property (!ce |-> !sclk)
		else $error("sclk high with ce low");
	a_frame_start: assert property ($rose(ce) |-> s_clk_idle)
		else $error("sclk moved too soon after ce rose");
	a_sdi_hold: assert property ($rose(sclk) |-> s_bit_held [*8])
		else $error("sdi changed while sclk high");
	a_sclk_high: assert property ($fell(sclk) |-> run == 29)
		else $error("sclk high phase not 30 cycles");
	a_sclk_low: assert property ($rose(sclk) && rises != 0 |-> run == 29)
		else $error("sclk low phase not 30 cycles");
	a_rise_count: assert property ($fell(ce) |-> rises == 16 || rises == 17)
		else $error("frame did not hold 16 or 17 rises");
	a_ce_gap: assert property ($rose(ce) |-> low >= 30 && !$past(sclk))
		else $error("ce low gap shorter than 30 cycles");
endmodule : rtcs_assertions

// ==== rtcs_tb.sv ====
// Purpose: Self-checking bench: host and device face each other over the link.
// Assumes: Short waits via parameters; APB offsets from the package, register bits as literals.
// Notes:   The host gets its own reset so a frame can be cut off mid-byte.
`timescale 1ns/1ps
module rtcs_tb
	import rtcs_pkg::*;
	;
	logic        clk_sys     = 1'b0;
	logic        host_resetn = 1'b0;
	logic        dev_resetn  = 1'b0;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h0000_0000;
	logic        main_ok     = 1'b1;
	logic        bat_ok      = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        irq;
	logic        on_main;
	logic        power_loss;
	logic        test_on;
	logic [31:0] r;
	int          n_mismatch  = 0;
	int          n_compared  = 0;
	always #5 clk_sys = ~clk_sys;
	////////////////////////////////////////
	rtcs_if rtcs_if_inst ();
	rtcs_host #(.ACC_CYC(2000), .TMO_CYC(3000), .RST_CYC(500)) rtcs_host_inst (
		.clk_sys(clk_sys), .resetn(host_resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .irq(irq), .main_ok(main_ok), .bus(rtcs_if_inst.host));
	rtcs_dev #(.POLL_CYC(200), .PROC_CYC(300)) rtcs_dev_inst (
		.clk_sys(clk_sys), .resetn(dev_resetn), .main_ok(main_ok), .bat_ok(bat_ok),
		.on_main(on_main), .power_loss(power_loss), .test_on(test_on),
		.bus(rtcs_if_inst.dev));
	rtcs_assertions rtcs_assertions_inst (
		.clk_sys(clk_sys), .resetn(host_resetn), .ce(rtcs_if_inst.ce),
		.sclk(rtcs_if_inst.sclk), .sdi(rtcs_if_inst.sdi), .sdo(rtcs_if_inst.sdo));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h expected=%h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		q = 32'h0000_0000;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready.
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h0000_0000, q);
	endtask : rd
	// Polling is bounded so a stuck status bit ends as a mismatch, not a hang.
	task automatic wait_bit(input logic [7:0] a, input int b);
		logic [31:0] q;
		q = 32'h0000_0000;
		for (int i = 0; i < 5000 && q[b] !== 1'b1; i++) rd(a, q);
		chk(q[b], 1'b1);
	endtask : wait_bit
	task automatic ser(input logic [15:0] c);
		wr(OFS_CMD, {16'h0000, c});
		wr(OFS_CTRL, 32'h0000_0004);
		wait_bit(OFS_ISTAT, 1);
		wr(OFS_ISTAT, 32'h0000_0002);
	endtask : ser
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	////////////////////////////////////////
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		n_mismatch++;
		results();
	end
	initial
	begin
		repeat (3) @(posedge clk_sys);
		host_resetn <= 1'b1;
		dev_resetn  <= 1'b1;
		rd(OFS_IMASK, r);
		chk(r, {29'h0, IMASK_RST});
		chk(power_loss, 1'b1);
		wr(OFS_CMD, 32'h0000_1E00);
		wr(OFS_CTRL, 32'h0000_0004);
		repeat (100) @(posedge clk_sys);
		chk(rtcs_if_inst.ce, 1'b0);
		rd(OFS_STAT, r);
		chk(r[1:0], 2'h0);
		wait_bit(OFS_STAT, 1);
		chk(on_main, 1'b1);
		ser(16'h1E00);
		chk(power_loss, 1'b0);
		for (logic [3:0] b = 4'h1; b < 4'h8; b++)
		begin
			ser({b, 4'h4, 4'hA, b});
			ser({b | 4'h8, 12'h400});
			rd(OFS_STAT, r);
			chk(r[15:8], {4'hA, b});
		end
		ser(16'h8400);
		rd(OFS_STAT, r);
		chk(r[15:8], 8'h00);
		// Cut the host off before the data byte is complete.
		wr(OFS_CMD, 32'h0000_243C);
		wr(OFS_CTRL, 32'h0000_0004);
		repeat (900) @(posedge clk_sys);
		host_resetn <= 1'b0;
		@(posedge clk_sys);
		host_resetn <= 1'b1;
		wait_bit(OFS_STAT, 1);
		ser(16'hA400);
		rd(OFS_STAT, r);
		chk(r[15:8], 8'hA2);
		ser(16'h3F80);
		chk(test_on, 1'b0);
		wr(OFS_IMASK, 32'h0000_0002);
		wr(OFS_CTRL, 32'h0000_0001);
		for (int i = 0; i < 8000 && test_on !== 1'b1; i++) @(posedge clk_sys);
		chk(test_on, 1'b1);
		wait_bit(OFS_ISTAT, 0);
		chk(test_on, 1'b0);
		chk(power_loss, 1'b1);
		rd(OFS_STAT, r);
		chk(r[2], 1'b0);
		chk(irq, 1'b0);
		wr(OFS_IMASK, 32'h0000_0003);
		repeat (2) @(posedge clk_sys);
		chk(irq, 1'b1);
		wr(OFS_ISTAT, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		chk(irq, 1'b0);
		ser(16'hA400);
		rd(OFS_STAT, r);
		chk(r[15:8], 8'h00);
		wr(OFS_CTRL, 32'h0000_0003);
		wait_bit(OFS_ISTAT, 0);
		rd(OFS_ISTAT, r);
		chk(r[2], 1'b0);
		rd(OFS_STAT, r);
		// The reread after the clear is the last flag read, so it shows zero.
		chk(r[2], 1'b0);
		ser(16'h1E00);
		bat_ok <= 1'b1;
		repeat (20) @(posedge clk_sys);
		chk(power_loss, 1'b1);
		main_ok <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk(on_main, 1'b0);
		rd(OFS_STAT, r);
		chk(r[1], 1'b0);
		main_ok <= 1'b1;
		for (int i = 0; i < 220 && on_main !== 1'b1; i++) @(posedge clk_sys);
		chk(on_main, 1'b1);
		rd(OFS_STAT, r);
		chk(r[1], 1'b0);
		wait_bit(OFS_STAT, 1);
		results();
	end
endmodule : rtcs_tb
